// [pfcs_scheduler.sv]
// pfcs_scheduler: four up-down time bases, two-phase pwm, conversion triggers,
// current averaging, line rectification and a latched bus overvoltage trip.
// assumes conversion results arrive synchronous to i_clk with a valid pulse.
module pfcs_scheduler (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cmp_wr,
  input wire logic [1:0] i_cmp_unit,
  input wire pfcs_pkg::pfcs_cmp_sel_t i_cmp_sel,
  input wire logic [pfcs_pkg::CNT_W-1:0] i_cmp_value,
  input wire logic i_cur_valid,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_cur_data,
  input wire logic i_line_valid,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_line_data,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_neutral_data,
  input wire logic i_bus_valid,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_bus_data,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_ovp_threshold,
  output logic o_pwm_a,
  output logic o_pwm_b,
  output logic [pfcs_pkg::SOC_N-1:0] o_soc,
  output logic o_soc_dummy,
  output logic o_ctrl_irq,
  output logic o_cur_loop_tick,
  output logic o_volt_loop_tick,
  output logic [pfcs_pkg::Q_W-1:0] o_cur_avg,
  output logic o_cur_avg_valid,
  output logic [pfcs_pkg::Q_W-1:0] o_vrect,
  output logic o_line_positive,
  output logic [pfcs_pkg::Q_W-1:0] o_bus_q24,
  output logic o_tripped
);

  typedef struct packed {
    logic [pfcs_pkg::UNITS-1:0][pfcs_pkg::CNT_W-1:0] cnt;
    logic [pfcs_pkg::UNITS-1:0] up;
    logic [pfcs_pkg::UNITS-1:0][pfcs_pkg::CNT_W-1:0] sh_a;
    logic [pfcs_pkg::UNITS-1:0][pfcs_pkg::CNT_W-1:0] sh_b;
    logic [pfcs_pkg::UNITS-1:0][pfcs_pkg::CNT_W-1:0] act_a;
    logic [pfcs_pkg::UNITS-1:0][pfcs_pkg::CNT_W-1:0] act_b;
    logic irq_phase;
    logic volt_phase;
    logic [2:0] n_samp;
    logic [pfcs_pkg::ACC_W-1:0] acc;
    logic trip;
    logic pwm_a;
    logic pwm_b;
    logic [pfcs_pkg::SOC_N-1:0] soc;
    logic soc_dummy;
    logic irq;
    logic vtick;
    logic [pfcs_pkg::Q_W-1:0] cur_avg;
    logic cur_avg_valid;
    logic [pfcs_pkg::Q_W-1:0] vrect;
    logic line_pos;
    logic [pfcs_pkg::Q_W-1:0] bus_q;
  } pfcs_state_t;

  localparam pfcs_state_t ST_RST = '{
    cnt: pfcs_pkg::CNT_RST,
    up: pfcs_pkg::UP_RST,
    sh_a: pfcs_pkg::CMP_FIRST_RST,
    sh_b: pfcs_pkg::CMP_SECOND_RST,
    act_a: pfcs_pkg::CMP_FIRST_RST,
    act_b: pfcs_pkg::CMP_SECOND_RST,
    irq_phase: 1'b0,
    volt_phase: 1'b0,
    n_samp: 3'h0,
    acc: '0,
    trip: 1'b0,
    pwm_a: 1'b0,
    pwm_b: 1'b0,
    soc: '0,
    soc_dummy: 1'b0,
    irq: 1'b0,
    vtick: 1'b0,
    cur_avg: '0,
    cur_avg_valid: 1'b0,
    vrect: '0,
    line_pos: 1'b0,
    bus_q: '0
  };

  // result rescale: full scale maps to just under 1.0, sign bit stays clear
  function automatic logic [pfcs_pkg::Q_W-1:0] to_q24(input logic [pfcs_pkg::ADC_W-1:0] v);
    to_q24 = {{(pfcs_pkg::Q_W - pfcs_pkg::Q_FRAC){1'b0}}, v, {(pfcs_pkg::Q_FRAC - pfcs_pkg::ADC_W){1'b0}}};
  endfunction

  pfcs_state_t q_ff;
  pfcs_state_t nxt_q;

  logic [pfcs_pkg::UNITS-1:0] at_zero;
  logic [pfcs_pkg::UNITS-1:0] match_a_up;
  logic [pfcs_pkg::UNITS-1:0] match_b_up;
  logic two_a_down;
  logic switch_on;
  logic [pfcs_pkg::ACC_W-1:0] sum;
  logic [pfcs_pkg::ADC_W-1:0] diff;

  always_comb begin
    nxt_q = q_ff;
    // event decode from the current counter state
    for (int u = 0; u < pfcs_pkg::UNITS; u++) begin
      at_zero[u] = (q_ff.cnt[u] == '0);
      match_a_up[u] = (q_ff.cnt[u] == q_ff.act_a[u]) && q_ff.up[u];
      match_b_up[u] = (q_ff.cnt[u] == q_ff.act_b[u]) && q_ff.up[u];
    end
    two_a_down = (q_ff.cnt[pfcs_pkg::U_TWO] == q_ff.act_a[pfcs_pkg::U_TWO]) && !q_ff.up[pfcs_pkg::U_TWO];
    // channel a centred on unit one zero, channel b on its peak: 180 deg apart
    switch_on = q_ff.pwm_a || q_ff.pwm_b;

    // four independent up-down time bases
    for (int u = 0; u < pfcs_pkg::UNITS; u++) begin
      if (q_ff.up[u]) begin
        nxt_q.cnt[u] = q_ff.cnt[u] + 8'h01;
        if (q_ff.cnt[u] + 8'h01 == pfcs_pkg::PERIOD) begin
          nxt_q.up[u] = 1'b0;
        end
      end else begin
        nxt_q.cnt[u] = q_ff.cnt[u] - 8'h01;
        if (q_ff.cnt[u] == 8'h01) begin
          nxt_q.up[u] = 1'b1;
        end
      end
    end

    // shadow writes; a write in the load cycle lands in shadow only
    if (i_cmp_wr) begin
      if (i_cmp_sel == pfcs_pkg::PFCS_SEL_FIRST) begin
        nxt_q.sh_a[i_cmp_unit] = i_cmp_value;
      end else if (i_cmp_sel == pfcs_pkg::PFCS_SEL_SECOND) begin
        nxt_q.sh_b[i_cmp_unit] = i_cmp_value;
      end
    end
    if (at_zero[pfcs_pkg::U_ONE]) begin
      nxt_q.act_a = q_ff.sh_a;
      nxt_q.act_b = q_ff.sh_b;
    end

    // conversion triggers, all from the four time bases
    nxt_q.soc[pfcs_pkg::SOC_ONE_ZERO] = at_zero[pfcs_pkg::U_ONE];
    nxt_q.soc[pfcs_pkg::SOC_ONE_PERIOD] = (q_ff.cnt[pfcs_pkg::U_ONE] == pfcs_pkg::PERIOD);
    nxt_q.soc[pfcs_pkg::SOC_TWO_UP] = match_a_up[pfcs_pkg::U_TWO];
    nxt_q.soc[pfcs_pkg::SOC_TWO_DOWN] = two_a_down;
    nxt_q.soc[pfcs_pkg::SOC_THREE_ZERO] = at_zero[pfcs_pkg::U_THREE];
    // the voltage conversions are held off while both switches are off
    nxt_q.soc[pfcs_pkg::SOC_THREE_SECOND] = match_b_up[pfcs_pkg::U_THREE] && switch_on;
    nxt_q.soc[pfcs_pkg::SOC_FOUR_FIRST] = match_a_up[pfcs_pkg::U_FOUR] && switch_on;
    nxt_q.soc[pfcs_pkg::SOC_FOUR_SECOND] = match_b_up[pfcs_pkg::U_FOUR] && switch_on;
    nxt_q.soc_dummy = at_zero[pfcs_pkg::U_THREE];

    // interrupt on every other match halves the pwm rate
    nxt_q.irq = 1'b0;
    nxt_q.vtick = 1'b0;
    if (match_b_up[pfcs_pkg::U_TWO]) begin
      nxt_q.irq_phase = !q_ff.irq_phase;
      if (q_ff.irq_phase) begin
        nxt_q.irq = 1'b1;
        nxt_q.volt_phase = !q_ff.volt_phase;
        nxt_q.vtick = q_ff.volt_phase;
      end
    end

    // current oversampling average
    sum = q_ff.acc + {{pfcs_pkg::AVG_SHIFT{1'b0}}, i_cur_data};
    nxt_q.cur_avg_valid = 1'b0;
    if (i_cur_valid) begin
      nxt_q.n_samp = q_ff.n_samp + 3'h1;
      if (q_ff.n_samp == pfcs_pkg::AVG_LAST) begin
        nxt_q.cur_avg = to_q24(sum[pfcs_pkg::ACC_W-1:pfcs_pkg::AVG_SHIFT]);
        nxt_q.cur_avg_valid = 1'b1;
        nxt_q.acc = '0;
      end else begin
        nxt_q.acc = sum;
      end
    end

    // line polarity and rectification
    if (i_line_data >= i_neutral_data) begin
      diff = i_line_data - i_neutral_data;
    end else begin
      diff = i_neutral_data - i_line_data;
    end
    if (i_line_valid) begin
      nxt_q.line_pos = (i_line_data >= i_neutral_data);
      nxt_q.vrect = to_q24(diff);
    end

    // overvoltage compare in the q24 domain; latch has no clear but reset
    if (i_bus_valid) begin
      nxt_q.bus_q = to_q24(i_bus_data);
      if (to_q24(i_bus_data) > to_q24(i_ovp_threshold)) begin
        nxt_q.trip = 1'b1;
      end
    end

    // outputs follow the counter that is about to be shown, trip wins
    nxt_q.pwm_a = (nxt_q.cnt[pfcs_pkg::U_ONE] < nxt_q.act_a[pfcs_pkg::U_ONE]) && !nxt_q.trip;
    nxt_q.pwm_b = (nxt_q.cnt[pfcs_pkg::U_ONE] > pfcs_pkg::PERIOD - nxt_q.act_b[pfcs_pkg::U_ONE])
                  && !nxt_q.trip;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q_ff <= ST_RST;
    end else if (i_ce) begin
      q_ff <= nxt_q;
    end
  end

  assign o_pwm_a = q_ff.pwm_a;
  assign o_pwm_b = q_ff.pwm_b;
  assign o_soc = q_ff.soc;
  assign o_soc_dummy = q_ff.soc_dummy;
  assign o_ctrl_irq = q_ff.irq;
  assign o_cur_loop_tick = q_ff.irq;
  assign o_volt_loop_tick = q_ff.vtick;
  assign o_cur_avg = q_ff.cur_avg;
  assign o_cur_avg_valid = q_ff.cur_avg_valid;
  assign o_vrect = q_ff.vrect;
  assign o_line_positive = q_ff.line_pos;
  assign o_bus_q24 = q_ff.bus_q;
  assign o_tripped = q_ff.trip;

  // checks run only while the clock enable lets state move
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n || !i_ce);

  chk_turn_zero: assert property (q_ff.cnt[0] == 8'h00 |=> q_ff.cnt[0] == 8'h01 && q_ff.up[0])
    else $error("unit one did not turn upward at zero");
  chk_turn_peak: assert property (q_ff.cnt[0] == 8'h96 |=> q_ff.cnt[0] == 8'h95 && !q_ff.up[0])
    else $error("unit one did not turn downward at period");
  chk_soc_one_zero: assert property (q_ff.cnt[0] == 8'h00 |=> o_soc[0] ##1 !o_soc[0])
    else $error("unit one zero trigger missing or too long");
  chk_soc_two_dir: assert property ((q_ff.cnt[1] == q_ff.act_a[1]) |=> (o_soc[2] != o_soc[3]))
    else $error("unit two trigger direction wrong");
  chk_soc_three: assert property (o_soc[4] |-> $past(q_ff.cnt[2]) == 8'h00)
    else $error("unit three zero trigger at wrong count");
  chk_dummy_pair: assert property (o_soc_dummy == o_soc[4])
    else $error("dummy conversion not with unit three zero");
  chk_volt_gate: assert property (o_soc[7] |-> $past(q_ff.pwm_a || q_ff.pwm_b))
    else $error("voltage conversion started with switches off");
  chk_irq_match: assert property (o_ctrl_irq |-> $past(q_ff.cnt[1]) == $past(q_ff.act_b[1]) && $past(q_ff.up[1]))
    else $error("interrupt without unit two second compare");
  chk_irq_half: assert property (o_ctrl_irq |=> !o_ctrl_irq [*8])
    else $error("interrupt repeated too soon");
  chk_turn_two: assert property (q_ff.cnt[1] == 8'h00 |=> q_ff.cnt[1] == 8'h01 && q_ff.up[1])
    else $error("unit two did not turn upward at zero");
  chk_soc_period: assert property (q_ff.cnt[0] == 8'h96 |=> o_soc[1])
    else $error("unit one period trigger missing");
  chk_soc_three_b: assert property (o_soc[5] |-> $past(q_ff.cnt[2]) == $past(q_ff.act_b[2]) && $past(q_ff.up[2]))
    else $error("unit three second compare trigger at wrong count");
  chk_soc_four_a: assert property (o_soc[6] |-> $past(q_ff.cnt[3]) == $past(q_ff.act_a[3]) && $past(q_ff.up[3]))
    else $error("unit four first compare trigger at wrong count");
  chk_volt_tick: assert property (o_volt_loop_tick |-> o_ctrl_irq)
    else $error("voltage tick outside an interrupt");
  chk_line_sign: assert property (i_line_valid |=> o_line_positive == ($past(i_line_data) >= $past(i_neutral_data)))
    else $error("line polarity wrong");
  chk_bus_rescale: assert property (i_bus_valid |=> o_bus_q24 == {8'h00, $past(i_bus_data), 12'h000})
    else $error("bus sample rescale wrong");
  chk_shadow_load: assert property (q_ff.cnt[0] == 8'h00 |=> q_ff.act_a == $past(q_ff.sh_a))
    else $error("shadow not loaded at unit one zero");
  chk_ov_trip: assert property (i_bus_valid && i_bus_data > i_ovp_threshold |=> o_tripped && !o_pwm_a && !o_pwm_b)
    else $error("overvoltage did not trip outputs");
  chk_trip_hold: assert property (o_tripped |=> o_tripped && !o_pwm_a && !o_pwm_b)
    else $error("outputs recovered after trip");

  cov_irq: cover property (o_ctrl_irq ##1 o_volt_loop_tick == 1'b0);
  cov_avg: cover property (o_cur_avg_valid);
  cov_trip: cover property (!o_tripped ##1 o_tripped);
  cov_volt_tick: cover property (o_volt_loop_tick);

endmodule

// [pfcs_pkg.sv]
// pfcs_pkg: constants shared by the pfc pwm and conversion-trigger scheduler.
// assumes a single clock domain; all timing values are counts of that clock.
package pfcs_pkg;

  localparam int CNT_W = 8;
  localparam int ADC_W = 12;
  localparam int Q_W = 32;
  localparam int Q_FRAC = 24;
  localparam int UNITS = 4;

  // up-down period register; one pwm cycle is twice this
  localparam logic [CNT_W-1:0] PERIOD = 8'h96;
  localparam int CYCLE_CLOCKS = 2 * 150;

  // samples averaged per current-loop value, and the matching shift
  localparam logic [2:0] AVG_LAST = 3'h7;
  localparam int AVG_SHIFT = 3;
  localparam int ACC_W = ADC_W + AVG_SHIFT;

  // unit indices
  localparam int U_ONE = 0;
  localparam int U_TWO = 1;
  localparam int U_THREE = 2;
  localparam int U_FOUR = 3;

  // start-of-conversion trigger bit positions
  localparam int SOC_ONE_ZERO = 0;
  localparam int SOC_ONE_PERIOD = 1;
  localparam int SOC_TWO_UP = 2;
  localparam int SOC_TWO_DOWN = 3;
  localparam int SOC_THREE_ZERO = 4;
  localparam int SOC_THREE_SECOND = 5;
  localparam int SOC_FOUR_FIRST = 6;
  localparam int SOC_FOUR_SECOND = 7;
  localparam int SOC_N = 8;

  // reset values of compare registers (shadow and active alike)
  localparam logic [UNITS-1:0][CNT_W-1:0] CMP_FIRST_RST = {8'h28, 8'h14, 8'h28, 8'h00};
  localparam logic [UNITS-1:0][CNT_W-1:0] CMP_SECOND_RST = {8'h3c, 8'h1e, 8'h50, 8'h96};

  // reset phase of each counter: unit two starts at the peak, 180 deg away
  localparam logic [UNITS-1:0][CNT_W-1:0] CNT_RST = {8'h00, 8'h00, 8'h96, 8'h00};
  localparam logic [UNITS-1:0] UP_RST = 4'b1101;

  typedef enum logic [1:0] {
    PFCS_SEL_FIRST = 2'b01,
    PFCS_SEL_SECOND = 2'b10
  } pfcs_cmp_sel_t;

endpackage

// [pfcs_adc_model.sv]
// pfcs_adc_model: conversion sequencer answering the scheduler's start triggers.
// assumes triggers are registered pulses; results return half a cycle later, on the falling edge.
module pfcs_adc_model (
  input wire logic i_clk,
  input wire logic [pfcs_pkg::SOC_N-1:0] i_soc,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_cur_val,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_line_val,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_neu_val,
  input wire logic [pfcs_pkg::ADC_W-1:0] i_bus_val,
  output logic o_cur_valid,
  output logic [pfcs_pkg::ADC_W-1:0] o_cur_data,
  output logic o_line_valid,
  output logic [pfcs_pkg::ADC_W-1:0] o_line_data,
  output logic [pfcs_pkg::ADC_W-1:0] o_neu_data,
  output logic o_bus_valid,
  output logic [pfcs_pkg::ADC_W-1:0] o_bus_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_cur_valid, o_line_valid, o_bus_valid} = 3'h0;
    {o_cur_data, o_line_data, o_neu_data, o_bus_data} = '0;
  end
  // data toggles when not valid, so a stale sample never looks right
  always @(negedge i_clk) begin
    o_cur_valid <= |i_soc[3:0];
    o_cur_data <= (|i_soc[3:0]) ? i_cur_val : ~o_cur_data;
    o_line_valid <= i_soc[pfcs_pkg::SOC_THREE_SECOND];
    o_line_data <= i_soc[pfcs_pkg::SOC_THREE_SECOND] ? i_line_val : ~o_line_data;
    o_neu_data <= i_soc[pfcs_pkg::SOC_THREE_SECOND] ? i_neu_val : ~o_neu_data;
    o_bus_valid <= i_soc[pfcs_pkg::SOC_FOUR_FIRST];
    o_bus_data <= i_soc[pfcs_pkg::SOC_FOUR_FIRST] ? i_bus_val : ~o_bus_data;
  end
endmodule

// [tb.sv]
// tb: self-checking bench for the pfc scheduler with the conversion model.
// assumes one 200 MHz clock; inputs change on the falling edge.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_rst_n = 1'b0, wr = 1'b0;
  logic [1:0] unit = 2'h0;
  pfcs_pkg::pfcs_cmp_sel_t sel = pfcs_pkg::PFCS_SEL_FIRST;
  logic [7:0] val = 8'h00;
  logic [11:0] cur_v = 12'h000, line_v = 12'h000, neu_v = 12'h000, bus_v = 12'h000, thr = 12'hfff;
  logic cv, lv, bv, pa, pb, dum, irq, clt, vlt, avv, lpos, trip;
  logic [11:0] cd, ld, nd, bd;
  logic [7:0] soc;
  logic [31:0] avg, vrect, busq;
  int fail_count = 0, cmp_count = 0, n;
  initial forever #2.5 i_clk = ~i_clk;
  pfcs_scheduler u_pfcs_scheduler (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cmp_wr(wr),
    .i_cmp_unit(unit), .i_cmp_sel(sel), .i_cmp_value(val), .i_cur_valid(cv), .i_cur_data(cd),
    .i_line_valid(lv), .i_line_data(ld), .i_neutral_data(nd), .i_bus_valid(bv), .i_bus_data(bd),
    .i_ovp_threshold(thr), .o_pwm_a(pa), .o_pwm_b(pb), .o_soc(soc), .o_soc_dummy(dum),
    .o_ctrl_irq(irq), .o_cur_loop_tick(clt), .o_volt_loop_tick(vlt), .o_cur_avg(avg),
    .o_cur_avg_valid(avv), .o_vrect(vrect), .o_line_positive(lpos), .o_bus_q24(busq), .o_tripped(trip));
  pfcs_adc_model u_pfcs_adc_model (.i_clk(i_clk), .i_soc(soc), .i_cur_val(cur_v), .i_line_val(line_v),
    .i_neu_val(neu_v), .i_bus_val(bus_v), .o_cur_valid(cv), .o_cur_data(cd), .o_line_valid(lv),
    .o_line_data(ld), .o_neu_data(nd), .o_bus_valid(bv), .o_bus_data(bd));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  function automatic logic sig(input int w);
    return w < 8 ? soc[w] : w == 8 ? irq : w == 9 ? vlt : avv;
  endfunction
  // cycles until signal w is seen high; the bound stops a hang
  task automatic wait_n(input int w, output int c);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (sig(w) !== 1'b1 && c < 3000);
    if (c >= 3000) chk(1'b0, 1'b1, "wait bound");
  endtask
  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
  endtask
  task automatic q24(input logic [11:0] r, output logic [31:0] q);
    q = {8'h00, r, 12'h000};
  endtask
  task automatic wr_cmp(input logic [1:0] u, input logic [1:0] s, input logic [7:0] v);
    unit = u;
    sel = pfcs_pkg::pfcs_cmp_sel_t'(s);
    val = v;
    wr = 1'b1;
    @(negedge i_clk);
  endtask
  task automatic t_period();
    wait_n(pfcs_pkg::SOC_ONE_ZERO, n);
    wait_n(pfcs_pkg::SOC_ONE_PERIOD, n);
    chk(n, 150, "zero to period");
    wait_n(pfcs_pkg::SOC_ONE_ZERO, n);
    chk(n, 150, "period to zero");
    chk(soc[pfcs_pkg::SOC_TWO_UP] | soc[pfcs_pkg::SOC_TWO_DOWN], 1'b0, "unit two quiet");
    $display("test period done");
  endtask
  task automatic t_irq();
    wait_n(8, n);
    wait_n(8, n);
    chk(n, 600, "irq spacing");
    chk(clt, 1'b1, "current tick");
    wait_n(9, n);
    wait_n(9, n);
    chk(n, 1200, "volt tick spacing");
    $display("test irq done");
  endtask
  task automatic t_avg();
    logic [31:0] e;
    cur_v = 12'h801;
    wait_n(10, n);
    wait_n(10, n);
    chk(n, 600, "avg spacing");
    q24(12'h801, e);
    chk(avg, e, "current average");
    $display("test avg done");
  endtask
  task automatic t_line();
    logic [31:0] e;
    line_v = 12'h300;
    neu_v = 12'h100;
    repeat (400) @(negedge i_clk);
    q24(12'h200, e);
    chk(vrect, e, "rectified pos");
    chk(lpos, 1'b1, "positive half");
    line_v = 12'h0ff;
    neu_v = 12'h3ff;
    repeat (400) @(negedge i_clk);
    q24(12'h300, e);
    chk(vrect, e, "rectified neg");
    chk(lpos, 1'b0, "negative half");
    $display("test line done");
  endtask
  task automatic t_trip();
    logic [31:0] e;
    int hi;
    thr = 12'h700;
    bus_v = 12'h700;
    repeat (400) @(negedge i_clk);
    q24(12'h700, e);
    chk(busq, e, "bus rescale");
    chk(trip, 1'b0, "equal no trip");
    bus_v = 12'h701;
    repeat (400) @(negedge i_clk);
    chk(trip, 1'b1, "over trips");
    bus_v = 12'h000;
    hi = 0;
    repeat (600) begin
      @(negedge i_clk);
      hi += int'(pa | pb);
    end
    chk(hi, 0, "pwm held low");
    chk(trip, 1'b1, "no self recovery");
    do_reset();
    @(negedge i_clk);
    chk(trip, 1'b0, "reset clears");
    $display("test trip done");
  endtask
  task automatic t_shadow();
    int a, b;
    wait_n(pfcs_pkg::SOC_ONE_PERIOD, n);
    wr_cmp(2'h0, 2'b01, 8'h14);
    wr_cmp(2'h0, 2'b10, 8'h14);
    wr_cmp(2'h0, 2'b11, 8'h50);
    wr = 1'b0;
    a = 0;
    while (soc[pfcs_pkg::SOC_ONE_ZERO] !== 1'b1) begin
      a += int'(pa);
      @(negedge i_clk);
    end
    chk(a, 0, "shadow not active yet");
    {a, b} = 64'h0;
    repeat (300) begin
      @(negedge i_clk);
      a += int'(pa);
      b += int'(pb);
    end
    chk(a, 39, "pwm a width");
    chk(b, 39, "pwm b width");
    $display("test shadow done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    do_reset();
    chk({pa, pb, trip, soc}, 11'h000, "reset outputs");
    t_period();
    t_irq();
    t_avg();
    t_line();
    t_trip();
    t_shadow();
    tally_and_finish();
  end
  // tests need about 7500 cycles; the watchdog at 20000 cycles marks a hang
  initial begin
    #100us;
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    tally_and_finish();
  end
endmodule
